/* hw/cause_defs.svh */
// Register offsets, bit positions, reset values and sizes for the cause block
`ifndef CAUSE_DEFS_SVH
`define CAUSE_DEFS_SVH
`define ADDR_W 8
`define CAUSE_OFS 8'h00
`define MASK_SET_OFS 8'h04
`define MASK_CLR_OFS 8'h08
`define CTRL_OFS 8'h0C
`define SPSIZE_OFS 8'h10
`define CAUSE_RST 32'h00000000
`define MASK_RST 32'h00000000
`define CTRL_RST 32'h00000000
`define SPSIZE_RST 16'h0000
`define SPSIZE_W 16
`define CAUSE_USED_MASK 32'h0001FE80
`define BIT_RXT 7
`define BIT_MGMT_ACCESS_DONE_CAUSE 9
`define BIT_CFG 10
`define BIT_RSV11 11
`define BIT_PHY 12
`define BIT_PINA 13
`define BIT_PINB 14
`define BIT_TXLOW 15
`define BIT_SMALL 16
`define CTL_PHY_EN 1
`define CTL_PINA_EN 2
`define CTL_PINB_EN 3
`define CTL_SERDES 4
`define CTL_PINC_EN 5
`endif

/* hw/cause_pkg.sv */
// Types shared by the cause block
package cause_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        VARIANT_STD = 2'h1,
        VARIANT_PIN3 = 2'h2
    } variant_e;
endpackage

/* hw/interrupt_cause_upper_bits.sv */
// Upper interrupt cause flags with mask, read-to-clear and host interrupt
`timescale 1ns/10ps
`include "cause_defs.svh"

module interrupt_cause_upper_bits
    import cause_pkg::*;
#(
    parameter variant_e VARIANT = VARIANT_STD,
    parameter bit MSG_INTR = 1'b0
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic rx_timer_expire_in,
    input wire logic mgmt_access_done_in,
    input wire logic rx_config_word_flag_in,
    input wire logic transceiver_irq_in,
    input wire logic soft_pin_a_in,
    input wire logic soft_pin_b_in,
    input wire logic soft_pin_c_in,
    input wire logic tx_desc_low_in,
    input wire logic rx_pkt_done_in,
    input wire logic [`SPSIZE_W-1:0] rx_pkt_len_in,
    input wire logic [6:0] lower_cause_in,
    output logic rx_desc_flush_out,
    output logic irq_out,
    output logic irq_msg_valid_out,
    output logic irq_msg_level_out
);

    // Only the two known variants have a pin map
    if (VARIANT != VARIANT_STD && VARIANT != VARIANT_PIN3) begin : g_bad_variant
        $error("Unsupported variant");
    end

    // Pins and the transceiver line come from outside the clock domain
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end else begin
            pin_meta_ff <= {transceiver_irq_in, soft_pin_c_in, soft_pin_b_in, soft_pin_a_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    wire pin_a = pin_sync_ff[0];
    wire pin_b = pin_sync_ff[1];
    wire pin_c = pin_sync_ff[2];
    wire phy_irq = pin_sync_ff[3];

    logic [31:0] cause_ff;
    logic [31:0] mask_ff;
    logic [31:0] ctrl_ff;
    logic [`SPSIZE_W-1:0] spsize_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic flush_ff;
    logic msg_valid_ff;
    logic msg_level_ff;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    wire rd_cause = rd_in && hit(addr_in, `CAUSE_OFS);
    wire wr_cause = wr_in && hit(addr_in, `CAUSE_OFS);
    wire wr_mset = wr_in && hit(addr_in, `MASK_SET_OFS);
    wire wr_mclr = wr_in && hit(addr_in, `MASK_CLR_OFS);
    wire wr_ctrl = wr_in && hit(addr_in, `CTRL_OFS);
    wire wr_spsize = wr_in && hit(addr_in, `SPSIZE_OFS);

    wire serdes_mode = ctrl_ff[`CTL_SERDES];
    wire phy_en = ctrl_ff[`CTL_PHY_EN];
    wire small_pkt = rx_pkt_done_in && (spsize_ff != `SPSIZE_RST)
        && (rx_pkt_len_in <= spsize_ff);
    wire pin3 = (VARIANT == VARIANT_PIN3);

    logic [31:0] set_vec;
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[`BIT_RXT] = rx_timer_expire_in;
        set_vec[`BIT_MGMT_ACCESS_DONE_CAUSE] = mgmt_access_done_in;
        set_vec[`BIT_CFG] = rx_config_word_flag_in && serdes_mode;
        set_vec[`BIT_PHY] = phy_irq && phy_en;
        set_vec[`BIT_PINA] = pin_a && ctrl_ff[`CTL_PINA_EN];
        set_vec[`BIT_PINB] = pin_b && ctrl_ff[`CTL_PINB_EN];
        set_vec[`BIT_RSV11] = pin3 && pin_c && ctrl_ff[`CTL_PINC_EN];
        set_vec[`BIT_TXLOW] = tx_desc_low_in;
        set_vec[`BIT_SMALL] = small_pkt;
    end

    // Set wins over a read clear or a write-one clear landing in the same cycle
    wire [31:0] clr_vec = rd_cause ? 32'hFFFFFFFF : (wr_cause ? wdata_in : 32'h00000000);
    wire [31:0] nxt_cause = ((cause_ff & ~clr_vec) | set_vec) & `CAUSE_USED_MASK;
    wire [31:0] nxt_mask = ((mask_ff | (wr_mset ? wdata_in : 32'h00000000))
        & ~(wr_mclr ? wdata_in : 32'h00000000)) & `CAUSE_USED_MASK;
    wire pending = |(nxt_cause & nxt_mask);
    wire [31:0] cause_view = {cause_ff[31:7], lower_cause_in};

    logic [31:0] nxt_rdata;
    always_comb begin
        case (addr_in)
            `CAUSE_OFS: nxt_rdata = cause_view;
            `MASK_SET_OFS: nxt_rdata = mask_ff;
            `CTRL_OFS: nxt_rdata = ctrl_ff;
            `SPSIZE_OFS: nxt_rdata = {16'h0000, spsize_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cause_ff <= `CAUSE_RST;
            mask_ff <= `MASK_RST;
            ctrl_ff <= `CTRL_RST;
            spsize_ff <= `SPSIZE_RST;
        end else begin
            cause_ff <= nxt_cause;
            mask_ff <= nxt_mask;
            if (wr_ctrl) begin
                ctrl_ff <= wdata_in;
            end
            if (wr_spsize) begin
                spsize_ff <= wdata_in[`SPSIZE_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_ff <= 32'h00000000;
            irq_ff <= 1'b0;
            flush_ff <= 1'b0;
            msg_valid_ff <= 1'b0;
            msg_level_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_in ? nxt_rdata : 32'h00000000;
            // Pin only when messages are not used; level follows pending
            irq_ff <= pending && !MSG_INTR;
            flush_ff <= rx_timer_expire_in;
            // One message per change of level so the host sees every edge
            msg_valid_ff <= MSG_INTR && (pending != msg_level_ff);
            if (MSG_INTR) begin
                msg_level_ff <= pending;
            end
        end
    end

    assign rdata_out = rdata_ff;
    assign irq_out = irq_ff;
    assign rx_desc_flush_out = flush_ff;
    assign irq_msg_valid_out = msg_valid_ff;
    assign irq_msg_level_out = msg_level_ff;

    property p_timer_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        rx_timer_expire_in |=> cause_ff[`BIT_RXT] && rx_desc_flush_out;
    endproperty
    a_timer_sets: assert property (p_timer_sets) else $error("timer cause missing");

    property p_mgmt_access_done_cause_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        mgmt_access_done_in |=> cause_ff[`BIT_MGMT_ACCESS_DONE_CAUSE];
    endproperty
    a_mgmt_access_done_cause_sets: assert property (p_mgmt_access_done_cause_sets) else $error("mgmt cause missing");

    property p_cfg_mode;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(cause_ff[`BIT_CFG]) |-> $past(serdes_mode) && $past(rx_config_word_flag_in);
    endproperty
    a_cfg_mode: assert property (p_cfg_mode) else $error("config cause outside mode");

    property p_phy_gate;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(cause_ff[`BIT_PHY]) |-> $past(phy_en);
    endproperty
    a_phy_gate: assert property (p_phy_gate) else $error("phy cause without enable");

    sequence s_pin_a_seen;
        soft_pin_a_in && ctrl_ff[`CTL_PINA_EN] ##1 ctrl_ff[`CTL_PINA_EN] [*2];
    endsequence
    property p_pin_a;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_pin_a_seen ##0 $past(soft_pin_a_in, 2) |=> cause_ff[`BIT_PINA];
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a cause missing");

    property p_small_zero;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(cause_ff[`BIT_SMALL]) |-> $past(spsize_ff) != `SPSIZE_RST;
    endproperty
    a_small_zero: assert property (p_small_zero) else $error("small cause with size zero");

    property p_read_clears;
        @(posedge clk_in) disable iff (!reset_n_in)
        rd_cause && set_vec == 32'h00000000 |=> cause_ff == 32'h00000000;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_read_data;
        @(posedge clk_in) disable iff (!reset_n_in)
        rd_cause |=> rdata_out == $past(cause_view);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_w1c;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_cause && !rd_cause |=> (cause_ff & $past(wdata_in) & ~$past(set_vec)) == 32'h0;
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_set_wins;
        @(posedge clk_in) disable iff (!reset_n_in)
        rd_cause && set_vec[`BIT_MGMT_ACCESS_DONE_CAUSE] |=> cause_ff[`BIT_MGMT_ACCESS_DONE_CAUSE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

    property p_irq;
        @(posedge clk_in) disable iff (!reset_n_in)
        !MSG_INTR |-> irq_out == |(cause_ff & mask_ff);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    sequence s_pin_b_seen;
        soft_pin_b_in && ctrl_ff[`CTL_PINB_EN] ##1 ctrl_ff[`CTL_PINB_EN] [*2];
    endsequence
    property p_pin_b;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_pin_b_seen |=> cause_ff[`BIT_PINB];
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b cause missing");

    sequence s_phy_seen;
        transceiver_irq_in && phy_en ##1 phy_en [*2];
    endsequence
    property p_phy_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_phy_seen |=> cause_ff[`BIT_PHY];
    endproperty
    a_phy_sets: assert property (p_phy_sets) else $error("phy cause missing");

    sequence s_pin_c_seen;
        pin3 && soft_pin_c_in && ctrl_ff[`CTL_PINC_EN] ##1 ctrl_ff[`CTL_PINC_EN] [*2];
    endsequence
    property p_pin_c;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_pin_c_seen |=> cause_ff[`BIT_RSV11];
    endproperty
    a_pin_c: assert property (p_pin_c) else $error("pin c cause missing");

    property p_rsv_std;
        @(posedge clk_in) disable iff (!reset_n_in)
        !pin3 |-> !cause_ff[`BIT_RSV11];
    endproperty
    a_rsv_std: assert property (p_rsv_std) else $error("bit 11 set outside variant");

    property p_cfg_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        rx_config_word_flag_in && serdes_mode |=> cause_ff[`BIT_CFG];
    endproperty
    a_cfg_sets: assert property (p_cfg_sets) else $error("config cause missing");

    property p_txlow_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        tx_desc_low_in |=> cause_ff[`BIT_TXLOW];
    endproperty
    a_txlow_sets: assert property (p_txlow_sets) else $error("tx low cause missing");

    property p_small_sets;
        @(posedge clk_in) disable iff (!reset_n_in)
        rx_pkt_done_in && spsize_ff != `SPSIZE_RST && rx_pkt_len_in <= spsize_ff
            |=> cause_ff[`BIT_SMALL];
    endproperty
    a_small_sets: assert property (p_small_sets) else $error("small cause missing");

    property p_flush_pulse;
        @(posedge clk_in) disable iff (!reset_n_in)
        rx_desc_flush_out |-> $past(rx_timer_expire_in);
    endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("stray flush");

    property p_msg_level;
        @(posedge clk_in) disable iff (!reset_n_in)
        MSG_INTR |-> irq_msg_level_out == |(cause_ff & mask_ff);
    endproperty
    a_msg_level: assert property (p_msg_level) else $error("message level wrong");

    property p_msg_edge;
        @(posedge clk_in) disable iff (!reset_n_in)
        MSG_INTR |-> irq_msg_valid_out == $changed(irq_msg_level_out);
    endproperty
    a_msg_edge: assert property (p_msg_edge) else $error("message not on level change");

    property p_msg_no_pin;
        @(posedge clk_in) disable iff (!reset_n_in)
        MSG_INTR |-> !irq_out;
    endproperty
    a_msg_no_pin: assert property (p_msg_no_pin) else $error("pin used with messages");

    property p_mask_set;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_mset |=> (mask_ff & $past(wdata_in) & `CAUSE_USED_MASK)
            == ($past(wdata_in) & `CAUSE_USED_MASK);
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set");

    property p_mask_clr;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_mclr |=> (mask_ff & $past(wdata_in)) == 32'h00000000;
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");

    property p_sticky;
        @(posedge clk_in) disable iff (!reset_n_in)
        !rd_cause && !wr_cause |=> (cause_ff & $past(cause_ff)) == $past(cause_ff);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_rdata_idle;
        @(posedge clk_in) disable iff (!reset_n_in)
        !rd_in |=> rdata_out == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

    property p_w0_keeps;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_cause |=> (cause_ff & $past(cause_ff) & ~$past(wdata_in))
            == ($past(cause_ff) & ~$past(wdata_in));
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared flag");

endmodule

/* verification/host_bus_model.sv */
// Host software model driving the register strobe port
`timescale 1ns/10ps
`include "cause_defs.svh"
module host_bus_model (
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    output logic [`ADDR_W-1:0] addr_out,
    output logic [31:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h00000000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic write_reg(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        // Reserved cause bit is always written as zero
        wdata_out <= (a == `CAUSE_OFS) ? (d & ~32'h00000800) : d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        // Released bus shows inverted values so stale data is never trusted
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
    endtask
    task automatic read_reg(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule

/* verification/interrupt_cause_upper_bits_tb_top.sv */
// Directed testbench for the upper interrupt cause flags
`timescale 1ns/10ps
`include "cause_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module interrupt_cause_upper_bits_tb_top;
    import cause_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic [3:0] ev = 4'h0;
    logic [4:0] lvl = 5'h00;
    logic [15:0] len = 16'h0000;
    logic flush;
    logic irq;
    logic [31:0] rdata2;
    logic irq2;
    logic msg_vld;
    logic msg_lvl;
    word_t extra = 32'h00000000;
    word_t rv;
    int error_cnt = 0;
    int check_count = 0;
    localparam word_t LOW = 32'h0000002A;
    logic [15:0] sz [3] = '{16'h0000, 16'h0040, 16'h0040};
    logic [15:0] ln [3] = '{16'h0000, 16'h0040, 16'h0041};
    always #50 clk_in = ~clk_in;
    host_bus_model host_bus_model_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    interrupt_cause_upper_bits interrupt_cause_upper_bits_i (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .rx_timer_expire_in(ev[0]), .mgmt_access_done_in(ev[1]),
        .rx_config_word_flag_in(lvl[0]), .transceiver_irq_in(lvl[1]),
        .soft_pin_a_in(lvl[2]), .soft_pin_b_in(lvl[3]), .soft_pin_c_in(lvl[4]),
        .tx_desc_low_in(ev[2]), .rx_pkt_done_in(ev[3]), .rx_pkt_len_in(len),
        .lower_cause_in(LOW[6:0]), .rx_desc_flush_out(flush), .irq_out(irq),
        .irq_msg_valid_out(), .irq_msg_level_out());
    // Second copy in the pin variant with message signalling, fed the same stimulus
    interrupt_cause_upper_bits #(.VARIANT(VARIANT_PIN3), .MSG_INTR(1'b1))
        interrupt_cause_upper_bits_pin3_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata2),
        .rx_timer_expire_in(ev[0]), .mgmt_access_done_in(ev[1]),
        .rx_config_word_flag_in(lvl[0]), .transceiver_irq_in(lvl[1]),
        .soft_pin_a_in(lvl[2]), .soft_pin_b_in(lvl[3]), .soft_pin_c_in(lvl[4]),
        .tx_desc_low_in(ev[2]), .rx_pkt_done_in(ev[3]), .rx_pkt_len_in(len),
        .lower_cause_in(LOW[6:0]), .rx_desc_flush_out(), .irq_out(irq2),
        .irq_msg_valid_out(msg_vld), .irq_msg_level_out(msg_lvl));
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic fire(input int i);
        @(posedge clk_in);
        ev[i] <= 1'b1;
        @(posedge clk_in);
        ev <= 4'h0;
        #1;
    endtask
    task automatic hold(input logic [4:0] v);
        // Pins pass a two-flop synchroniser, so allow the lag both ways
        @(posedge clk_in);
        lvl <= v;
        repeat (4) @(posedge clk_in);
        lvl <= 5'h00;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input word_t e, input string n);
        host_bus_model_i.read_reg(a, rv);
        `CHK(n, e, rv)
        `CHK(n, e | extra, rdata2)
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rchk(`CAUSE_OFS, LOW, "cause_rst");
        rchk(`MASK_SET_OFS, `MASK_RST, "mask_rst");
        rchk(8'h3C, 32'h00000000, "unmapped");
        host_bus_model_i.write_reg(`MASK_SET_OFS, `CAUSE_USED_MASK);
        rchk(`MASK_SET_OFS, `CAUSE_USED_MASK, "mask");
        fire(0);
        `CHK("flush", 1'b1, flush)
        `CHK("irq_on", 1'b1, irq)
        `CHK("msg_on", 2'b11, {msg_vld, msg_lvl})
        `CHK("irq_pin", 1'b0, irq2)
        rchk(`CAUSE_OFS, LOW | 32'h00000080, "rxt");
        `CHK("irq_ack", 1'b0, irq)
        `CHK("msg_off", 2'b10, {msg_vld, msg_lvl})
        rchk(`CAUSE_OFS, LOW, "cleared");
        host_bus_model_i.write_reg(`MASK_CLR_OFS, 32'h00000080);
        fire(0);
        `CHK("irq_masked", 1'b0, irq)
        rchk(`CAUSE_OFS, LOW | 32'h00000080, "sticky");
        fire(1);
        fire(2);
        host_bus_model_i.write_reg(`CAUSE_OFS, 32'h00000200);
        rchk(`CAUSE_OFS, LOW | 32'h00008000, "w1c");
        fire(1);
        rchk(`CAUSE_OFS, LOW | 32'h00000200, "mgmt");
        hold(5'h1F);
        rchk(`CAUSE_OFS, LOW, "gated");
        host_bus_model_i.write_reg(`CTRL_OFS, 32'h0000003E);
        hold(5'h1F);
        // Only the pin variant maps the third pin onto bit 11
        extra = 32'h00000800;
        rchk(`CAUSE_OFS, LOW | 32'h00007400, "levels");
        extra = 32'h00000000;
        fork
            host_bus_model_i.read_reg(`CAUSE_OFS, rv);
            fire(1);
        join
        `CHK("race_rd", LOW, rv)
        rchk(`CAUSE_OFS, LOW | 32'h00000200, "race");
        for (int k = 0; k < 3; k++) begin
            host_bus_model_i.write_reg(`SPSIZE_OFS, {16'h0000, sz[k]});
            len <= ln[k];
            fire(3);
            rchk(`CAUSE_OFS, LOW | ((k == 1) ? 32'h00010000 : 32'h0), "small");
        end
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        error_cnt++;
        give_verdict();
    end
endmodule
